// ### pkg/ptp_pkg.sv
// shared codes for the pcie-to-pci transaction policy block
package ptp_pkg;
	// received or transmitted tlp kind
	localparam logic [3:0] TLP_MRD    = 4'h0;
	localparam logic [3:0] TLP_MRDLK  = 4'h1;
	localparam logic [3:0] TLP_MWR    = 4'h2;
	localparam logic [3:0] TLP_IORD   = 4'h3;
	localparam logic [3:0] TLP_IOWR   = 4'h4;
	localparam logic [3:0] TLP_CFGRD0 = 4'h5;
	localparam logic [3:0] TLP_CFGWR0 = 4'h6;
	localparam logic [3:0] TLP_CFGRD1 = 4'h7;
	localparam logic [3:0] TLP_CFGWR1 = 4'h8;
	localparam logic [3:0] TLP_MSG    = 4'h9;
	localparam logic [3:0] TLP_MSGD   = 4'ha;
	localparam logic [3:0] TLP_CPL    = 4'hb;
	localparam logic [3:0] TLP_CPLD   = 4'hc;
	localparam logic [3:0] TLP_CPLLK  = 4'hd;
	localparam logic [3:0] TLP_CPLDLK = 4'he;
	// message class of a received msg or msgd
	localparam logic [2:0] MSG_OTHER  = 3'h0;
	localparam logic [2:0] MSG_UNLOCK = 3'h1;
	localparam logic [2:0] MSG_SPL    = 3'h2;
	localparam logic [2:0] MSG_VDM0   = 3'h3;
	localparam logic [2:0] MSG_VDM1   = 3'h4;
	localparam logic [2:0] MSG_DEVID  = 3'h5;
	localparam logic [2:0] MSG_IGNORE = 3'h6;
	localparam logic [2:0] MSG_ERRSIG = 3'h7;
	localparam logic [2:0] MSG_INTX   = 3'h0;
	// verdict on a received tlp
	localparam logic [2:0] VD_FWD     = 3'h0;
	localparam logic [2:0] VD_DROP    = 3'h1;
	localparam logic [2:0] VD_UR      = 3'h2;
	localparam logic [2:0] VD_MALF    = 3'h3;
	localparam logic [2:0] VD_MABT    = 3'h4;
	localparam logic [2:0] VD_ABSORB  = 3'h5;
	// ordering class
	localparam logic [2:0] OC_POSTED  = 3'h0;
	localparam logic [2:0] OC_RDREQ   = 3'h1;
	localparam logic [2:0] OC_IOCWR   = 3'h2;
	localparam logic [2:0] OC_RDCPL   = 3'h3;
	localparam logic [2:0] OC_IOCCPL  = 3'h4;
	// slot power limit field layout in the message payload
	localparam int         SPL_VAL_LSB = 0;
	localparam int         SPL_SCL_LSB = 8;
	localparam logic [1:0] SPL_SCL_RST = 2'h0;
	localparam logic [7:0] SPL_VAL_RST = 8'h00;
	typedef enum logic [3:0] {
		LK_IDLE  = 4'b0001,
		LK_DRAIN = 4'b0010,
		LK_RDPCI = 4'b0100,
		LK_FULL  = 4'b1000
	} ptp_lock_state_t;
endpackage : ptp_pkg

// ### src/ptp_policy.sv
// transaction policy and downstream lock engine of the pcie-to-pci bridge
// Functional notes
// R1: receive and transmit only the allowed tlp kinds; others refused.
// R2: vendor messages never forwarded; type 1 dropped silently, type 0 unsupported.
// R3: device id messages end on pci side with master abort.
// R4: ignored messages dropped; error messages unsupported; intx messages malformed.
// R5: legacy interrupt level changes become assert and deassert messages upstream.
// R6: pci power events become pme messages upstream.
// R7: set slot power limit payload loads scale and value fields.
// R8: posted never passes earlier posted, relaxed ordering or not.
// R9: read completion passes posted only with relaxed ordering set.
// R10: requests and write completions never pass posted; all else may pass.
// R11: upstream lock signal ignored; lock only honoured downstream.
// R12: lock established on locked read, lock asserted, target trdy.
// R13: locked read enters target-lock; successful completion enters full-lock.
// R14: locked read issued only after all earlier requests complete.
// R15: in target-lock every received tlp but unlock unsupported; pci side still accepted.
// R16: full-lock retries upstream, non-memory downstream requests unsupported.
// R17: queued upstream requests and own messages held; early completions accepted.
// R18: unlock message ends lock and frees pci bus; an unlock in LK_RDPCI is absorbed without leaving that state.
// R19: pci lock driven on every downstream cycle while bus locked.
// R20: upstream side sends no non-locked traffic while locked.
// R21: abort on first locked read: no lock, error completion.
// R22: abort inside established lock keeps lock until unlock.
`timescale 1ns/10ps
`default_nettype none
module ptp_policy (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       rx_valid_i,
	input  wire logic [3:0] rx_type_i,
	input  wire logic [2:0] rx_msg_i,
	input  wire logic [9:0] rx_payload_i,
	input  wire logic       tx_valid_i,
	input  wire logic [3:0] tx_type_i,
	input  wire logic [2:0] ord_second_i,
	input  wire logic [2:0] ord_first_i,
	input  wire logic       ord_ro_i,
	input  wire logic       pci_drained_i,
	input  wire logic       lk_trdy_i,
	input  wire logic       lk_abort_i,
	input  wire logic [3:0] intx_n_i,
	input  wire logic       power_event_input_n_i,
	input  wire logic       msg_ready_i,
	output logic            rx_done_o,
	output logic [2:0]      rx_verdict_o,
	output logic            tx_allow_o,
	output logic            ord_pass_o,
	output logic [1:0]      spl_scale_o,
	output logic [7:0]      spl_value_o,
	output logic            lk_issue_o,
	output logic            lk_err_cpl_o,
	output logic            target_lock_o,
	output logic            full_lock_o,
	output logic            up_retry_o,
	output logic            up_hold_o,
	output logic            pci_bus_lock_output_n_o,
	output logic            pci_bus_lock_output_oe_o,
	output logic            int_msg_valid_o,
	output logic            int_msg_assert_o,
	output logic [1:0]      int_msg_line_o,
	output logic            pme_msg_valid_o
);
	ptp_pkg::ptp_lock_state_t st_r;
	ptp_pkg::ptp_lock_state_t st_nxt;
	logic [2:0] vd_nxt;
	logic [3:0] int_sent_r;
	logic [3:0] int_pend;
	logic       pme_seen_r;
	logic       msg_busy;
	logic       is_unlock;

	function automatic logic rx_ok(input logic [3:0] t);
		rx_ok = (t <= ptp_pkg::TLP_CPLD); // see R1
	endfunction : rx_ok

	function automatic logic tx_ok(input logic [3:0] t);
		case (t) // see R1
			ptp_pkg::TLP_MRD, ptp_pkg::TLP_MWR, ptp_pkg::TLP_IORD,
			ptp_pkg::TLP_IOWR, ptp_pkg::TLP_MSG, ptp_pkg::TLP_CPL,
			ptp_pkg::TLP_CPLD, ptp_pkg::TLP_CPLLK,
			ptp_pkg::TLP_CPLDLK: tx_ok = 1'b1;
			default: tx_ok = 1'b0;
		endcase
	endfunction : tx_ok

	function automatic logic is_msg(input logic [3:0] t);
		is_msg = (t == ptp_pkg::TLP_MSG) || (t == ptp_pkg::TLP_MSGD);
	endfunction : is_msg

	function automatic logic is_mem(input logic [3:0] t);
		is_mem = (t == ptp_pkg::TLP_MRD) || (t == ptp_pkg::TLP_MWR)
			|| (t == ptp_pkg::TLP_MRDLK);
	endfunction : is_mem

	function automatic logic [1:0] top_pend(input logic [3:0] p);
		top_pend = 2'h0;
		for (int i = 0; i < 4; i++)
			if (p[i])
				top_pend = 2'(i); // highest pending line wins, one line per message
	endfunction : top_pend

	function automatic logic is_cpl(input logic [3:0] t);
		is_cpl = (t == ptp_pkg::TLP_CPL) || (t == ptp_pkg::TLP_CPLD);
	endfunction : is_cpl

	function automatic logic can_pass(input logic [2:0] s, input logic [2:0] f,
			input logic ro);
		if (f != ptp_pkg::OC_POSTED)
			can_pass = 1'b1; // see R10
		else if (s == ptp_pkg::OC_RDCPL)
			can_pass = ro; // see R9
		else
			can_pass = 1'b0; // see R8
	endfunction : can_pass

	assign is_unlock = rx_valid_i && is_msg(rx_type_i)
		&& (rx_msg_i == ptp_pkg::MSG_UNLOCK);

	// verdict on each received tlp
	always_comb begin
		vd_nxt = ptp_pkg::VD_FWD;
		if (!rx_ok(rx_type_i)) begin
			vd_nxt = ptp_pkg::VD_UR; // see R1
		end else if (is_unlock) begin
			vd_nxt = ptp_pkg::VD_ABSORB; // see R18
		end else if (st_r == ptp_pkg::LK_DRAIN || st_r == ptp_pkg::LK_RDPCI) begin
			vd_nxt = ptp_pkg::VD_UR; // see R15
		end else if (st_r == ptp_pkg::LK_FULL && !is_mem(rx_type_i)
				&& !is_cpl(rx_type_i)) begin
			vd_nxt = ptp_pkg::VD_UR; // see R16
		end else if (is_msg(rx_type_i)) begin
			case (rx_msg_i)
				ptp_pkg::MSG_SPL:    vd_nxt = ptp_pkg::VD_ABSORB; // see R7
				ptp_pkg::MSG_VDM1:   vd_nxt = ptp_pkg::VD_DROP; // see R2
				ptp_pkg::MSG_VDM0:   vd_nxt = ptp_pkg::VD_UR; // see R2
				ptp_pkg::MSG_DEVID:  vd_nxt = ptp_pkg::VD_MABT; // see R3
				ptp_pkg::MSG_IGNORE: vd_nxt = ptp_pkg::VD_DROP; // see R4
				ptp_pkg::MSG_ERRSIG: vd_nxt = ptp_pkg::VD_UR; // see R4
				default:             vd_nxt = ptp_pkg::VD_MALF; // see R4
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_done_o    <= 1'b0;
			rx_verdict_o <= ptp_pkg::VD_FWD;
		end else begin
			rx_done_o    <= rx_valid_i;
			rx_verdict_o <= rx_valid_i ? vd_nxt : ptp_pkg::VD_FWD;
		end
	end

	// slot power limit fields; scale from payload bits 9:8, value from payload bits 7:0
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			spl_scale_o <= ptp_pkg::SPL_SCL_RST;
			spl_value_o <= ptp_pkg::SPL_VAL_RST;
		end else if (rx_valid_i && vd_nxt == ptp_pkg::VD_ABSORB
				&& rx_msg_i == ptp_pkg::MSG_SPL) begin
			spl_scale_o <= rx_payload_i[ptp_pkg::SPL_SCL_LSB +: 2]; // see R7
			spl_value_o <= rx_payload_i[ptp_pkg::SPL_VAL_LSB +: 8]; // see R7
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_allow_o <= 1'b0;
			ord_pass_o <= 1'b0;
		end else begin
			tx_allow_o <= tx_valid_i && tx_ok(tx_type_i); // see R1
			ord_pass_o <= can_pass(ord_second_i, ord_first_i, ord_ro_i); // see R8
		end
	end

	// lock engine; the pci-side lock input is never consulted for upstream work
	always_comb begin // see R11
		st_nxt = st_r;
		case (st_r)
			ptp_pkg::LK_IDLE:
				if (rx_valid_i && rx_type_i == ptp_pkg::TLP_MRDLK)
					st_nxt = ptp_pkg::LK_DRAIN; // see R13
			ptp_pkg::LK_DRAIN:
				if (is_unlock)
					st_nxt = ptp_pkg::LK_IDLE;
				else if (pci_drained_i)
					st_nxt = ptp_pkg::LK_RDPCI; // see R14
			ptp_pkg::LK_RDPCI:
				if (lk_abort_i)
					st_nxt = ptp_pkg::LK_IDLE; // see R21
				else if (lk_trdy_i)
					st_nxt = ptp_pkg::LK_FULL; // see R12
			ptp_pkg::LK_FULL:
				if (is_unlock)
					st_nxt = ptp_pkg::LK_IDLE; // see R18
			default: st_nxt = ptp_pkg::LK_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			st_r <= ptp_pkg::LK_IDLE;
		else
			st_r <= st_nxt; // see R22
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lk_issue_o    <= 1'b0;
			lk_err_cpl_o  <= 1'b0;
			target_lock_o <= 1'b0;
			full_lock_o   <= 1'b0;
			up_retry_o    <= 1'b0;
			up_hold_o     <= 1'b0;
		end else begin
			lk_issue_o    <= (st_r == ptp_pkg::LK_DRAIN)
				&& (st_nxt == ptp_pkg::LK_RDPCI); // see R14
			lk_err_cpl_o  <= (st_r == ptp_pkg::LK_RDPCI) && lk_abort_i; // see R21
			target_lock_o <= (st_nxt == ptp_pkg::LK_DRAIN)
				|| (st_nxt == ptp_pkg::LK_RDPCI); // see R13
			full_lock_o   <= (st_nxt == ptp_pkg::LK_FULL); // see R13
			up_retry_o    <= (st_nxt == ptp_pkg::LK_FULL); // see R16
			up_hold_o     <= (st_nxt == ptp_pkg::LK_FULL); // see R17
		end
	end

	// lock pin is driven low for the locked read and for the whole full-lock
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pci_bus_lock_output_n_o  <= 1'b1;
			pci_bus_lock_output_oe_o <= 1'b0;
		end else begin
			pci_bus_lock_output_n_o  <= !((st_nxt == ptp_pkg::LK_RDPCI)
				|| (st_nxt == ptp_pkg::LK_FULL)); // see R19
			pci_bus_lock_output_oe_o <= (st_nxt == ptp_pkg::LK_RDPCI)
				|| (st_nxt == ptp_pkg::LK_FULL); // see R19
		end
	end

	// interrupt and pme messages: one outstanding at a time, stalled under full lock
	assign int_pend = int_sent_r ^ ~intx_n_i;
	assign msg_busy = int_msg_valid_o || pme_msg_valid_o;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_sent_r       <= 4'h0;
			int_msg_valid_o  <= 1'b0;
			int_msg_assert_o <= 1'b0;
			int_msg_line_o   <= 2'h0;
		end else if (int_msg_valid_o) begin
			if (msg_ready_i)
				int_msg_valid_o <= 1'b0;
		end else if (!msg_busy && !up_hold_o && int_pend != 4'h0) begin // see R17
			int_msg_valid_o                <= 1'b1; // see R5
			int_msg_assert_o               <= ~intx_n_i[top_pend(int_pend)];
			int_msg_line_o                 <= top_pend(int_pend);
			int_sent_r[top_pend(int_pend)] <= ~intx_n_i[top_pend(int_pend)];
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pme_seen_r      <= 1'b0;
			pme_msg_valid_o <= 1'b0;
		end else begin
			if (power_event_input_n_i)
				pme_seen_r <= 1'b0;
			if (pme_msg_valid_o) begin
				if (msg_ready_i)
					pme_msg_valid_o <= 1'b0;
			end else if (!power_event_input_n_i && !pme_seen_r && !msg_busy
					&& !up_hold_o && int_pend == 4'h0) begin
				pme_msg_valid_o <= 1'b1; // see R6
				pme_seen_r      <= 1'b1;
			end
		end
	end

	property p_unlock_frees;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(st_r == ptp_pkg::LK_FULL && is_unlock) |=> !full_lock_o
			&& pci_bus_lock_output_oe_o == 1'b0;
	endproperty
	a_unlock_frees: assert property (p_unlock_frees) // see R18
		else $error("lock not released on unlock");

	property p_full_needs_trdy;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(full_lock_o) |-> $past(lk_trdy_i) && $past(st_r == ptp_pkg::LK_RDPCI);
	endproperty
	a_full_needs_trdy: assert property (p_full_needs_trdy) // see R12
		else $error("full lock without target ready on locked read");

	property p_abort_no_lock;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(st_r == ptp_pkg::LK_RDPCI && lk_abort_i) |=> lk_err_cpl_o && !full_lock_o;
	endproperty
	a_abort_no_lock: assert property (p_abort_no_lock) // see R21
		else $error("abort on locked read mishandled");

	property p_keep_lock;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(st_r == ptp_pkg::LK_FULL && !is_unlock) |=> full_lock_o && up_retry_o;
	endproperty
	a_keep_lock: assert property (p_keep_lock) // see R22
		else $error("full lock dropped without unlock");

	property p_issue_after_drain;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		lk_issue_o |-> $past(pci_drained_i) && !pci_bus_lock_output_n_o;
	endproperty
	a_issue_after_drain: assert property (p_issue_after_drain) // see R14
		else $error("locked read issued before drain");

	property p_tgt_ur;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rx_valid_i && target_lock_o && !is_unlock && st_r != ptp_pkg::LK_IDLE)
			|=> rx_verdict_o == ptp_pkg::VD_UR;
	endproperty
	a_tgt_ur: assert property (p_tgt_ur) // see R15
		else $error("tlp in target lock not unsupported");

	property p_vdm1_drop;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rx_valid_i && st_r == ptp_pkg::LK_IDLE && rx_type_i == ptp_pkg::TLP_MSG
			&& rx_msg_i == ptp_pkg::MSG_VDM1) |=> rx_verdict_o == ptp_pkg::VD_DROP;
	endproperty
	a_vdm1_drop: assert property (p_vdm1_drop) // see R2
		else $error("vendor type 1 message not dropped");

	property p_devid_mabt;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rx_valid_i && st_r == ptp_pkg::LK_IDLE && rx_type_i == ptp_pkg::TLP_MSG
			&& rx_msg_i == ptp_pkg::MSG_DEVID) |=> rx_verdict_o == ptp_pkg::VD_MABT;
	endproperty
	a_devid_mabt: assert property (p_devid_mabt) // see R3
		else $error("device id message not master aborted");

	property p_tx_never_lk;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(tx_valid_i && (tx_type_i == ptp_pkg::TLP_MRDLK || tx_type_i == ptp_pkg::TLP_MSGD))
			|=> !tx_allow_o;
	endproperty
	a_tx_never_lk: assert property (p_tx_never_lk) // see R1
		else $error("forbidden tlp allowed for transmit");

	property p_ord_post;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(ord_first_i == ptp_pkg::OC_POSTED && ord_second_i != ptp_pkg::OC_RDCPL)
			|=> !ord_pass_o;
	endproperty
	a_ord_post: assert property (p_ord_post) // see R8
		else $error("passing of posted request allowed");

	property p_held_msgs;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(up_hold_o && !msg_busy) |=> !int_msg_valid_o && !pme_msg_valid_o;
	endproperty
	a_held_msgs: assert property (p_held_msgs) // see R17
		else $error("message sent under lock");

	c_full: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(full_lock_o));
	c_abort: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		lk_err_cpl_o);
	c_intx: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		int_msg_valid_o && msg_ready_i);
endmodule : ptp_policy
`default_nettype wire

// ### testbench/ptp_policy_tb.sv
// self-checking bench for the transaction policy and lock engine
`timescale 1ns/10ps
`default_nettype none
module ptp_policy_tb;
	logic       ref_clk_i, reset_n_i, rx_valid_i, tx_valid_i, ord_ro_i, pci_drained_i;
	logic       lk_trdy_i, lk_abort_i, power_event_input_n_i, msg_ready_i;
	logic [3:0] rx_type_i, tx_type_i, intx_n_i, lat, last;
	logic [2:0] rx_msg_i, ord_second_i, ord_first_i, rx_verdict_o;
	logic [9:0] rx_payload_i;
	logic [1:0] spl_scale_o, int_msg_line_o;
	logic [7:0] spl_value_o, cnt;
	logic       rx_done_o, tx_allow_o, ord_pass_o, lk_issue_o, lk_err_cpl_o, target_lock_o;
	logic       full_lock_o, up_retry_o, up_hold_o, pci_bus_lock_output_n_o;
	logic       pci_bus_lock_output_oe_o, int_msg_valid_o, int_msg_assert_o, pme_msg_valid_o;
	int         errors, checked, cycles;

	ptp_policy dut (.ref_clk_i, .reset_n_i, .rx_valid_i, .rx_type_i, .rx_msg_i, .rx_payload_i,
		.tx_valid_i, .tx_type_i, .ord_second_i, .ord_first_i, .ord_ro_i, .pci_drained_i,
		.lk_trdy_i, .lk_abort_i, .intx_n_i, .power_event_input_n_i, .msg_ready_i, .rx_done_o,
		.rx_verdict_o, .tx_allow_o, .ord_pass_o, .spl_scale_o, .spl_value_o, .lk_issue_o,
		.lk_err_cpl_o, .target_lock_o, .full_lock_o, .up_retry_o, .up_hold_o,
		.pci_bus_lock_output_n_o, .pci_bus_lock_output_oe_o, .int_msg_valid_o,
		.int_msg_assert_o, .int_msg_line_o, .pme_msg_valid_o);
	ptp_upstream_model up (.ref_clk_i, .reset_n_i, .int_valid_i(int_msg_valid_o),
		.int_assert_i(int_msg_assert_o), .int_line_i(int_msg_line_o),
		.pme_valid_i(pme_msg_valid_o), .lat_i(lat), .msg_ready_o(msg_ready_i),
		.msg_cnt_o(cnt), .msg_last_o(last));

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask : step
	task automatic rx(input logic [3:0] t, input logic [2:0] m, input logic [2:0] v);
		rx_type_i  = t;
		rx_msg_i   = m;
		rx_valid_i = 1'b1;
		step();
		check(rx_done_o, 1'b1);
		check(rx_verdict_o, v);
		rx_valid_i = 1'b0;
		step();
	endtask : rx
	task automatic wait_msg(input logic [7:0] n, input logic [3:0] exp);
		for (int i = 0; i < 40 && cnt !== n; i++) step();
		check(cnt, n);
		check(last, exp);
	endtask : wait_msg
	task automatic t_tx();
		tx_valid_i = 1'b1;
		for (int i = 0; i < 16; i++) begin
			tx_type_i = i[3:0];
			step();
			check(tx_allow_o, tx_type_i inside {ptp_pkg::TLP_MRD, ptp_pkg::TLP_MWR,
				ptp_pkg::TLP_IORD, ptp_pkg::TLP_IOWR, ptp_pkg::TLP_MSG, ptp_pkg::TLP_CPL,
				ptp_pkg::TLP_CPLD, ptp_pkg::TLP_CPLLK, ptp_pkg::TLP_CPLDLK});
		end
		tx_valid_i = 1'b0;
		$display("transmit kinds test done");
	endtask : t_tx
	task automatic t_rx();
		rx(ptp_pkg::TLP_CFGWR1, ptp_pkg::MSG_OTHER, ptp_pkg::VD_FWD);
		rx(ptp_pkg::TLP_CPLDLK, ptp_pkg::MSG_OTHER, ptp_pkg::VD_UR);
		rx(ptp_pkg::TLP_MSGD, ptp_pkg::MSG_VDM1, ptp_pkg::VD_DROP);
		rx(ptp_pkg::TLP_MSGD, ptp_pkg::MSG_VDM0, ptp_pkg::VD_UR);
		rx(ptp_pkg::TLP_MSG, ptp_pkg::MSG_DEVID, ptp_pkg::VD_MABT);
		rx(ptp_pkg::TLP_MSG, ptp_pkg::MSG_IGNORE, ptp_pkg::VD_DROP);
		rx(ptp_pkg::TLP_MSG, ptp_pkg::MSG_ERRSIG, ptp_pkg::VD_UR);
		rx(ptp_pkg::TLP_MSG, ptp_pkg::MSG_INTX, ptp_pkg::VD_MALF);
		rx_payload_i = 10'h2a5;
		rx(ptp_pkg::TLP_MSGD, ptp_pkg::MSG_SPL, ptp_pkg::VD_ABSORB);
		check({spl_scale_o, spl_value_o}, 10'h2a5);
		$display("receive verdict test done");
	endtask : t_rx
	task automatic t_ord();
		for (int f = 0; f < 5; f++)
			for (int s = 0; s < 10; s++) begin
				ord_first_i  = f[2:0];
				ord_second_i = s[3:1];
				ord_ro_i     = s[0];
				step();
				check(ord_pass_o, !(f == 0 && (s[3:1] != ptp_pkg::OC_RDCPL || !s[0])));
			end
		$display("ordering test done");
	endtask : t_ord
	// under full lock only memory traffic and completions follow, bar one io read probing refusal and the closing unlock message
	task automatic t_lock();
		rx(ptp_pkg::TLP_MRDLK, ptp_pkg::MSG_OTHER, ptp_pkg::VD_FWD);
		check(target_lock_o, 1'b1);
		rx(ptp_pkg::TLP_MWR, ptp_pkg::MSG_OTHER, ptp_pkg::VD_UR);
		check(lk_issue_o, 1'b0);
		pci_drained_i = 1'b1;
		step();
		pci_drained_i = 1'b0;
		check({lk_issue_o, pci_bus_lock_output_n_o, pci_bus_lock_output_oe_o}, 3'b101);
		lk_trdy_i = 1'b1;
		step();
		lk_trdy_i = 1'b0;
		check({full_lock_o, up_retry_o, up_hold_o, target_lock_o}, 4'b1110);
		intx_n_i[0] = 1'b0;
		rx(ptp_pkg::TLP_MRD, ptp_pkg::MSG_OTHER, ptp_pkg::VD_FWD);
		rx(ptp_pkg::TLP_IORD, ptp_pkg::MSG_OTHER, ptp_pkg::VD_UR);
		rx(ptp_pkg::TLP_CPLD, ptp_pkg::MSG_OTHER, ptp_pkg::VD_FWD);
		lk_abort_i = 1'b1;
		step();
		lk_abort_i = 1'b0;
		check({full_lock_o, int_msg_valid_o, pci_bus_lock_output_n_o}, 3'b100);
		rx(ptp_pkg::TLP_MSG, ptp_pkg::MSG_UNLOCK, ptp_pkg::VD_ABSORB);
		check({full_lock_o, up_hold_o, pci_bus_lock_output_oe_o}, 3'b000);
		wait_msg(8'h01, 4'b0100);
		intx_n_i[0] = 1'b1;
		wait_msg(8'h02, 4'b0000);
		$display("lock test done");
	endtask : t_lock
	task automatic t_abort();
		rx(ptp_pkg::TLP_MRDLK, ptp_pkg::MSG_OTHER, ptp_pkg::VD_FWD);
		pci_drained_i = 1'b1;
		step();
		pci_drained_i = 1'b0;
		lk_abort_i    = 1'b1;
		step();
		lk_abort_i = 1'b0;
		check({lk_err_cpl_o, full_lock_o, target_lock_o}, 3'b100);
		$display("locked read abort test done");
	endtask : t_abort
	task automatic t_msg();
		lat         = 4'h3;
		intx_n_i[3] = 1'b0;
		wait_msg(8'h03, 4'b0111);
		power_event_input_n_i = 1'b0;
		wait_msg(8'h04, 4'b1000);
		power_event_input_n_i = 1'b1;
		intx_n_i[3]           = 1'b1;
		wait_msg(8'h05, 4'b0011);
		$display("message test done");
	endtask : t_msg
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		{reset_n_i, rx_valid_i, tx_valid_i, ord_ro_i, pci_drained_i, lk_trdy_i, lk_abort_i} = 7'h00;
		{rx_type_i, tx_type_i, rx_msg_i, ord_second_i, ord_first_i, rx_payload_i} = 27'h0;
		intx_n_i              = 4'hf;
		power_event_input_n_i = 1'b1;
		lat                   = 4'h0;
		errors                = 0;
		checked               = 0;
		cycles                = 0;
		repeat (5) @(posedge ref_clk_i);
		#1;
		reset_n_i = 1'b1;
		t_tx();
		t_rx();
		t_ord();
		t_lock();
		t_abort();
		t_msg();
		results();
	end
endmodule : ptp_policy_tb
`default_nettype wire

// ### testbench/ptp_upstream_model.sv
// upstream port model: takes offered messages after a set delay and logs them
`timescale 1ns/10ps
`default_nettype none
module ptp_upstream_model (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       int_valid_i,
	input  wire logic       int_assert_i,
	input  wire logic [1:0] int_line_i,
	input  wire logic       pme_valid_i,
	input  wire logic [3:0] lat_i,
	output logic            msg_ready_o,
	output logic [7:0]      msg_cnt_o,
	output logic [3:0]      msg_last_o
);
	logic       offer;
	logic [3:0] wait_r;
	assign offer = int_valid_i || pme_valid_i;
	// an offer must stand lat_i+1 cycles before it is taken, so slow links are covered too
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_r      <= 4'h0;
			msg_ready_o <= 1'b0;
		end else if (msg_ready_o) begin
			wait_r      <= 4'h0;
			msg_ready_o <= 1'b0;
		end else if (offer && wait_r == lat_i) begin
			msg_ready_o <= 1'b1;
		end else if (offer) begin
			wait_r <= wait_r + 4'h1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			msg_cnt_o  <= 8'h00;
			msg_last_o <= 4'h0;
		end else if (msg_ready_o && offer) begin
			msg_cnt_o  <= msg_cnt_o + 8'h01;
			// interrupt fields only count while an interrupt message is offered
			msg_last_o <= {pme_valid_i, int_valid_i & int_assert_i,
				int_valid_i ? int_line_i : 2'h0};
		end
	end
endmodule : ptp_upstream_model
`default_nettype wire
